// ### rtl/dec_map.svh
// Functional notes
// - Counters read as read-only nibble pairs
// - Counter B nibbles at 2FAH and 2FBH
// - Reset leaves both counters at 00H
// - Writing D0 one clears counter A
// - Writing D1 one clears counter B
// - Clear bits always read back zero
// - Run bit gates counting, resets zero
// - Mode bit: zero phase, one separate
// - Run changes act at rejector falling edge
// - Each counter is eight-bit binary up-counter
// - Phase mode: leading input picks counter
// - Separate mode: each input own counter
// - Rejector clock is oscillator over 16/128
`ifndef DEC_MAP_SVH
`define DEC_MAP_SVH

// ----------------------------------------------------------------------
// Register indices; the byte address is four times the index.
// ----------------------------------------------------------------------
`define DEC_IDX_A_LOW   12'h2f8
`define DEC_IDX_A_HIGH  12'h2f9
`define DEC_IDX_B_LOW   12'h2fa
`define DEC_IDX_B_HIGH  12'h2fb
`define DEC_IDX_CTRL    12'h2fc
`define DEC_ADDR_W      14

// ----------------------------------------------------------------------
// Control register fields and reset values.
// ----------------------------------------------------------------------
`define DEC_BIT_CLR_A   0
`define DEC_BIT_CLR_B   1
`define DEC_BIT_RUN     2
`define DEC_BIT_MODE    3
`define DEC_CNT_RST     8'h00
`define DEC_RUN_RST     1'b0
`define DEC_MODE_RST    1'b0

// ----------------------------------------------------------------------
// Noise rejector divider last counts, one less than the ratio in oscillator periods.
// ----------------------------------------------------------------------
`define DEC_DIV_SLOW    7'h7f
`define DEC_DIV_FAST    7'h0f

// ----------------------------------------------------------------------
// AXI responses.
// ----------------------------------------------------------------------
`define DEC_RESP_OKAY   2'b00
`define DEC_RESP_SLVERR 2'b10

`endif

// ### rtl/dec_pkg.sv
package dec_pkg;
  typedef logic [7:0] dec_count_t;
  typedef logic [3:0] dec_nibble_t;
  typedef enum logic {DEC_PHASE, DEC_SEPARATE} dec_mode_t;
  typedef enum {DEC_W_IDLE, DEC_W_RESP} dec_wstate_t;
  typedef enum {DEC_R_IDLE, DEC_R_RESP} dec_rstate_t;
endpackage

// ### rtl/dec_rej_if.sv
`timescale 1ns/1ns
interface dec_rej_if;
  logic       fallTick;
  logic [1:0] level;
  logic [1:0] rise;
  modport src (output fallTick, output level, output rise);
  modport dst (input fallTick, input level, input rise);
endinterface

// ### rtl/dec_noise_rejector.sv
`timescale 1ns/1ns
`include "dec_map.svh"
module dec_noise_rejector import dec_pkg::*; #(
  parameter bit DIV_BY_128 = 1'b0
) (
  // Clock and control
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic ce,
  // Oscillator and pins
  input  wire logic lowSpeedOscClock,
  input  wire logic pulseInputA,
  input  wire logic pulseInputB,
  // Filtered result
  dec_rej_if.src    rej
);
  localparam logic [6:0] DIV_LAST = DIV_BY_128 ? `DEC_DIV_SLOW : `DEC_DIV_FAST;
  localparam logic [6:0] DIV_HALF = 7'((8'(DIV_LAST) + 8'h01) >> 1);

  logic       oscPrev_q, oscPrev_d;
  logic [6:0] div_q, div_d;
  logic [1:0] samp_q, samp_d;
  logic [1:0] level_q, level_d;
  logic [1:0] rise_q, rise_d;
  logic       fall_q, fall_d;
  logic       oscEdge;
  logic [1:0] pins;

  // ----------------------------------------------------------------------
  // Divider and two-sample filter.
  // ----------------------------------------------------------------------
  // A level is accepted only when two samples one rejector period apart
  // agree, so a glitch shorter than half a period can never pass.
  always_comb begin
    pins      = {pulseInputB, pulseInputA};
    oscEdge   = lowSpeedOscClock & ~oscPrev_q;
    oscPrev_d = lowSpeedOscClock;
    div_d     = div_q;
    samp_d    = samp_q;
    level_d   = level_q;
    fall_d    = 1'b0;
    if (oscEdge) begin
      div_d = (div_q == DIV_LAST) ? 7'h00 : div_q + 7'h01;
      fall_d = (div_q == DIV_HALF - 7'h01);
      if (div_q == DIV_LAST) begin
        samp_d = pins;
        level_d = (pins == samp_q) ? pins : level_q;
      end
    end
    rise_d = level_d & ~level_q;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      oscPrev_q <= 1'b0;
      div_q     <= 7'h00;
      samp_q    <= 2'h0;
      level_q   <= 2'h0;
      rise_q    <= 2'h0;
      fall_q    <= 1'b0;
    end else if (ce) begin
      oscPrev_q <= oscPrev_d;
      div_q     <= div_d;
      samp_q    <= samp_d;
      level_q   <= level_d;
      rise_q    <= rise_d;
      fall_q    <= fall_d;
    end
  end

  assign rej.fallTick = fall_q;
  assign rej.level    = level_q;
  assign rej.rise     = rise_q;
endmodule

// ### rtl/dec_event_counter.sv
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`include "dec_map.svh"
module dec_event_counter import dec_pkg::*; #(
  parameter bit DIV_BY_128 = 1'b0
) (
  // Clock, reset, enable
  input  wire logic                   clk_sys,
  input  wire logic                   rst,
  input  wire logic                   ce,
  // Pins
  input  wire logic                   lowSpeedOscClock,
  input  wire logic                   pulseInputA,
  input  wire logic                   pulseInputB,
  output logic                        portLevelA,
  output logic                        portLevelB,
  // AXI4-Lite write address and data
  input  wire logic [`DEC_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  // AXI4-Lite read
  input  wire logic [`DEC_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready
);

  dec_rej_if rej ();

  dec_noise_rejector #(.DIV_BY_128(DIV_BY_128)) uRej (
    .clk_sys          (clk_sys),
    .rst              (rst),
    .ce               (ce),
    .lowSpeedOscClock (lowSpeedOscClock),
    .pulseInputA      (pulseInputA),
    .pulseInputB      (pulseInputB),
    .rej              (rej.src)
  );

  // ----------------------------------------------------------------------
  // Address decode.
  // ----------------------------------------------------------------------
  // Only whole words decode; the two low address bits are ignored, and any
  // unmapped word answers with a slave error so software notices the slip.
  function automatic logic [2:0] decodeIdx(input logic [`DEC_ADDR_W-1:0] addr);
    logic [11:0] idx;
    idx = addr[`DEC_ADDR_W-1:2];
    case (idx)
      `DEC_IDX_A_LOW:  decodeIdx = 3'h1;
      `DEC_IDX_A_HIGH: decodeIdx = 3'h2;
      `DEC_IDX_B_LOW:  decodeIdx = 3'h3;
      `DEC_IDX_B_HIGH: decodeIdx = 3'h4;
      `DEC_IDX_CTRL:   decodeIdx = 3'h5;
      default:         decodeIdx = 3'h0;
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // Write channel.
  // ----------------------------------------------------------------------
  dec_wstate_t           wState_q, wState_d;
  logic                  awHeld_q, awHeld_d;
  logic                  wHeld_q, wHeld_d;
  logic [`DEC_ADDR_W-1:0] awAddr_q, awAddr_d;
  logic [3:0]            wData_q, wData_d;
  logic                  wLane_q, wLane_d;
  logic                  awReady_q, awReady_d;
  logic                  wReady_q, wReady_d;
  logic                  bValid_q, bValid_d;
  logic [1:0]            bResp_q, bResp_d;
  logic                  doWrite;
  logic [2:0]            wSel;

  always_comb begin
    wState_d  = wState_q;
    awHeld_d  = awHeld_q;
    wHeld_d   = wHeld_q;
    awAddr_d  = awAddr_q;
    wData_d   = wData_q;
    wLane_d   = wLane_q;
    bValid_d  = bValid_q;
    bResp_d   = bResp_q;
    doWrite   = 1'b0;
    wSel      = decodeIdx(awAddr_q);
    if (s_axi_awvalid && awReady_q) begin
      awHeld_d = 1'b1;
      awAddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && wReady_q) begin
      wHeld_d = 1'b1;
      wData_d = s_axi_wdata[3:0];
      wLane_d = s_axi_wstrb[0];
    end
    case (wState_q)
      DEC_W_IDLE: begin
        if (awHeld_q && wHeld_q) begin
          doWrite  = wLane_q;
          bValid_d = 1'b1;
          bResp_d  = (wSel == 3'h0) ? `DEC_RESP_SLVERR : `DEC_RESP_OKAY;
          wState_d = DEC_W_RESP;
        end
      end
      DEC_W_RESP: begin
        if (s_axi_bready) begin
          bValid_d = 1'b0;
          awHeld_d = 1'b0;
          wHeld_d  = 1'b0;
          wState_d = DEC_W_IDLE;
        end
      end
      default: wState_d = DEC_W_IDLE;
    endcase
    awReady_d = ~awHeld_d;
    wReady_d  = ~wHeld_d;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wState_q  <= DEC_W_IDLE;
      awHeld_q  <= 1'b0;
      wHeld_q   <= 1'b0;
      awAddr_q  <= '0;
      wData_q   <= 4'h0;
      wLane_q   <= 1'b0;
      awReady_q <= 1'b0;
      wReady_q  <= 1'b0;
      bValid_q  <= 1'b0;
      bResp_q   <= `DEC_RESP_OKAY;
    end else if (ce) begin
      wState_q  <= wState_d;
      awHeld_q  <= awHeld_d;
      wHeld_q   <= wHeld_d;
      awAddr_q  <= awAddr_d;
      wData_q   <= wData_d;
      wLane_q   <= wLane_d;
      awReady_q <= awReady_d;
      wReady_q  <= wReady_d;
      bValid_q  <= bValid_d;
      bResp_q   <= bResp_d;
    end
  end

  // ----------------------------------------------------------------------
  // Control bits and counters.
  // ----------------------------------------------------------------------
  logic       runCtrl_q, runCtrl_d;
  dec_mode_t  mode_q, mode_d;
  logic       runActive_q, runActive_d;
  dec_count_t cntA_q, cntA_d;
  dec_count_t cntB_q, cntB_d;
  logic       stepA;
  logic       stepB;
  logic       ctrlWr;

  // The run bit only reaches the counters at the next rejector falling tick,
  // so a pulse that is half way through the filter is never cut in two.

  always_comb begin
    ctrlWr      = doWrite && (wSel == 3'h5);
    runCtrl_d   = ctrlWr ? wData_q[`DEC_BIT_RUN] : runCtrl_q;
    mode_d      = ctrlWr ? dec_mode_t'(wData_q[`DEC_BIT_MODE]) : mode_q;
    runActive_d = rej.fallTick ? runCtrl_q : runActive_q;
    stepA       = 1'b0;
    stepB       = 1'b0;
    if (runActive_q) begin
      case (mode_q)
        // A rise while the other input is already high means the other led.
        DEC_PHASE: begin
          stepB = rej.rise[1] & ~rej.rise[0] & rej.level[0];
          stepA = rej.rise[0] & ~rej.rise[1] & rej.level[1];
        end
        DEC_SEPARATE: begin
          stepA = rej.rise[0];
          stepB = rej.rise[1];
        end
        default: begin
          stepA = 1'b0;
          stepB = 1'b0;
        end
      endcase
    end
    // Writes to the count nibbles fall through here and leave the count alone.
    cntA_d = stepA ? cntA_q + 8'h01 : cntA_q;
    cntB_d = stepB ? cntB_q + 8'h01 : cntB_q;
    // A clear written in the same cycle as a pulse wins, so software sees 00H.
    if (ctrlWr && wData_q[`DEC_BIT_CLR_A]) begin
      cntA_d = `DEC_CNT_RST;
    end
    if (ctrlWr && wData_q[`DEC_BIT_CLR_B]) begin
      cntB_d = `DEC_CNT_RST;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      runCtrl_q   <= `DEC_RUN_RST;
      mode_q      <= dec_mode_t'(`DEC_MODE_RST);
      runActive_q <= `DEC_RUN_RST;
      cntA_q      <= `DEC_CNT_RST;
      cntB_q      <= `DEC_CNT_RST;
    end else if (ce) begin
      runCtrl_q   <= runCtrl_d;
      mode_q      <= mode_d;
      runActive_q <= runActive_d;
      cntA_q      <= cntA_d;
      cntB_q      <= cntB_d;
    end
  end

  // ----------------------------------------------------------------------
  // Read channel.
  // ----------------------------------------------------------------------
  dec_rstate_t rState_q, rState_d;
  logic        arReady_q, arReady_d;
  logic        rValid_q, rValid_d;
  logic [31:0] rData_q, rData_d;
  logic [1:0]  rResp_q, rResp_d;
  logic [1:0]  pinLvl_q, pinLvl_d;
  logic [3:0]  rdNib;
  logic [2:0]  rSel;

  // Reads are not synchronised to counting. A nibble pair read across a
  // carry can disagree, so software must read twice and keep a repeat.

  always_comb begin
    rState_d  = rState_q;
    rValid_d  = rValid_q;
    rData_d   = rData_q;
    rResp_d   = rResp_q;
    arReady_d = arReady_q;
    pinLvl_d  = rej.level;
    rSel      = decodeIdx(s_axi_araddr);
    case (rSel)
      3'h1:    rdNib = cntA_q[3:0];
      3'h2:    rdNib = cntA_q[7:4];
      3'h3:    rdNib = cntB_q[3:0];
      3'h4:    rdNib = cntB_q[7:4];
      3'h5:    rdNib = {mode_q, runCtrl_q, 2'b00};
      default: rdNib = 4'h0;
    endcase
    case (rState_q)
      DEC_R_IDLE: begin
        arReady_d = 1'b1;
        if (s_axi_arvalid && arReady_q) begin
          arReady_d = 1'b0;
          rValid_d  = 1'b1;
          rData_d   = {28'h0000000, rdNib};
          rResp_d   = (rSel == 3'h0) ? `DEC_RESP_SLVERR : `DEC_RESP_OKAY;
          rState_d  = DEC_R_RESP;
        end
      end
      DEC_R_RESP: begin
        if (s_axi_rready) begin
          rValid_d  = 1'b0;
          arReady_d = 1'b1;
          rState_d  = DEC_R_IDLE;
        end
      end
      default: rState_d = DEC_R_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rState_q  <= DEC_R_IDLE;
      arReady_q <= 1'b0;
      rValid_q  <= 1'b0;
      rData_q   <= 32'h00000000;
      rResp_q   <= `DEC_RESP_OKAY;
      pinLvl_q  <= 2'h0;
    end else if (ce) begin
      rState_q  <= rState_d;
      arReady_q <= arReady_d;
      rValid_q  <= rValid_d;
      rData_q   <= rData_d;
      rResp_q   <= rResp_d;
      pinLvl_q  <= pinLvl_d;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs, all straight from flip-flops.
  // ----------------------------------------------------------------------
  // The port levels keep following the pins even while counting is stopped.
  assign portLevelA    = pinLvl_q[0];
  assign portLevelB    = pinLvl_q[1];
  assign s_axi_awready = awReady_q;
  assign s_axi_wready  = wReady_q;
  assign s_axi_bvalid  = bValid_q;
  assign s_axi_bresp   = bResp_q;
  assign s_axi_arready = arReady_q;
  assign s_axi_rvalid  = rValid_q;
  assign s_axi_rdata   = rData_q;
  assign s_axi_rresp   = rResp_q;
endmodule

// ### test/dec_event_counter_props.sv
`timescale 1ns/1ns
`include "dec_map.svh"
module dec_event_counter_props (
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        rst,
  // Write side
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  // Read side
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence s_wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_b_done;
    s_axi_bvalid && s_axi_bready;
  endsequence
  a_b_latency: assert property (s_wr_both |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write answer late or early");
  a_r_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  a_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  a_wr_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  a_rd_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  a_rdata_nibble: assert property (s_axi_rvalid |-> s_axi_rdata[31:4] == 28'h0)
    else $error("read data above nibble not zero");
  a_wr_reopen: assert property (s_b_done |-> ##[1:2] (s_axi_awready && s_axi_wready))
    else $error("write ready not restored");
endmodule

// ### test/dec_pulse_src.sv
`timescale 1ns/1ns
module dec_pulse_src #(
  parameter int HOLD       = 400,
  parameter int BURST_HOLD = 80
) (
  // Clock
  input wire logic clk_sys,
  // Pins
  output logic     pinA,
  output logic     pinB
);
  initial begin
    pinA = 1'b0;
    pinB = 1'b0;
  end
  // One full cycle of two shifted pulses; each step outlasts two rejector
  // periods so the filter accepts every edge.
  task automatic quad(input bit aFirst);
    logic [3:0] sa;
    logic [3:0] sb;
    sa = aFirst ? 4'h3 : 4'h6;
    sb = aFirst ? 4'h6 : 4'h3;
    for (int i = 0; i < 4; i++) begin
      pinA <= sa[i];
      pinB <= sb[i];
      repeat (HOLD) @(posedge clk_sys);
    end
  endtask
  // Pulses both pins together; each level outlasts two rejector periods
  // while the oscillator toggles on every system clock.
  task automatic burst(input int n);
    for (int i = 0; i < n; i++) begin
      pinA <= 1'b1;
      pinB <= 1'b1;
      repeat (BURST_HOLD) @(posedge clk_sys);
      pinA <= 1'b0;
      pinB <= 1'b0;
      repeat (BURST_HOLD) @(posedge clk_sys);
    end
  endtask
endmodule

// ### test/tb_top.sv
`timescale 1ns/1ns
`include "dec_map.svh"
module tb_top;
  typedef struct {logic [11:0] idx; logic [31:0] d; logic [1:0] r;} dec_tb_row_t;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic        oscClk = 1'b0;
  logic        ce = 1'b1;
  logic [3:0]  wrStrb = 4'hf;
  logic        pinA, pinB, levA, levB;
  logic [13:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = '0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  int          n_fail = 0, total_checks = 0, cycles = 0;
  dec_tb_row_t rows[6] = '{
    '{`DEC_IDX_A_LOW, 32'h0, `DEC_RESP_OKAY}, '{`DEC_IDX_A_HIGH, 32'h0, `DEC_RESP_OKAY},
    '{`DEC_IDX_B_LOW, 32'h0, `DEC_RESP_OKAY}, '{`DEC_IDX_B_HIGH, 32'h0, `DEC_RESP_OKAY},
    '{`DEC_IDX_CTRL, 32'h0, `DEC_RESP_OKAY}, '{12'h2fd, 32'h0, `DEC_RESP_SLVERR}};

  initial forever #5 clk_sys = ~clk_sys;
  // The oscillator toggles on every system clock, so a rejector period is
  // 32 clocks; the cycle count also cuts a hang short.
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    oscClk <= ~oscClk;
    if (cycles == 80000) begin
      n_fail++;
      conclude();
    end
  end

  dec_event_counter #(.DIV_BY_128(1'b0)) u_dut (
    .clk_sys, .rst, .ce(ce), .lowSpeedOscClock(oscClk), .pulseInputA(pinA),
    .pulseInputB(pinB), .portLevelA(levA), .portLevelB(levB), .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);
  dec_pulse_src u_src (.clk_sys, .pinA, .pinB);

  // ----------------------------------------------------------------
  // Bus and check tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [11:0] idx, input logic [31:0] d, output logic [1:0] r);
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_wdata <= d;
    s_axi_wstrb <= wrStrb;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [11:0] idx, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge clk_sys);
  endtask
  // Reads the low nibble before and after the high nibble and checks that both low reads agree.
  task automatic cnt(input logic [11:0] lo, input logic [7:0] e);
    logic [31:0] a, b, c;
    logic [1:0]  r;
    rd(lo, a, r);
    rd(lo + 12'h1, b, r);
    rd(lo, c, r);
    chk(c, a);
    chk({24'h0, b[3:0], a[3:0]}, {24'h0, e});
  endtask
  task automatic counts(input logic [7:0] ea, input logic [7:0] eb);
    cnt(`DEC_IDX_A_LOW, ea);
    cnt(`DEC_IDX_B_LOW, eb);
    $display("test done at %0t", $time);
  endtask
  // The wait lets the run bit settle on a rejector falling tick first.
  task automatic ctl(input logic [3:0] v);
    logic [1:0] r;
    wr(`DEC_IDX_CTRL, {28'h0, v}, r);
    chk({30'h0, r}, {30'h0, `DEC_RESP_OKAY});
    repeat (300) @(posedge clk_sys);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    foreach (rows[i]) begin
      rd(rows[i].idx, d, r);
      chk(d, rows[i].d);
      chk({30'h0, r}, {30'h0, rows[i].r});
    end
    $display("reset map test done");
    fork
      u_src.quad(1'b1);
      begin
        repeat (700) @(posedge clk_sys);
        chk({30'h0, levB, levA}, 32'h3);
      end
    join
    chk({30'h0, levB, levA}, 32'h0);
    counts(8'h0, 8'h0);
    ctl(4'h4);
    u_src.quad(1'b1);
    u_src.quad(1'b1);
    counts(8'h0, 8'h2);
    u_src.quad(1'b0);
    counts(8'h1, 8'h2);
    ctl(4'hc);
    u_src.quad(1'b1);
    counts(8'h2, 8'h3);
    wr(`DEC_IDX_B_LOW, 32'h0, r);
    chk({30'h0, r}, {30'h0, `DEC_RESP_OKAY});
    counts(8'h2, 8'h3);
    ctl(4'hd);
    counts(8'h0, 8'h3);
    rd(`DEC_IDX_CTRL, d, r);
    chk(d, 32'hc);
    ctl(4'hc);
    counts(8'h0, 8'h3);
    ctl(4'he);
    counts(8'h0, 8'h0);
    // 257 joint pulses carry both counters through FFH and on to 01H.
    u_src.burst(257);
    counts(8'h1, 8'h1);
    // A write whose low strobe is clear must not apply the clears.
    wrStrb = 4'h0;
    wr(`DEC_IDX_CTRL, 32'h3, r);
    wrStrb = 4'hf;
    chk({30'h0, r}, {30'h0, `DEC_RESP_OKAY});
    counts(8'h1, 8'h1);
    // With the clock enable low the pulses must leave no trace.
    ce <= 1'b0;
    u_src.quad(1'b1);
    ce <= 1'b1;
    counts(8'h1, 8'h1);
    ctl(4'h8);
    u_src.quad(1'b0);
    counts(8'h1, 8'h1);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    counts(8'h0, 8'h0);
    rd(`DEC_IDX_CTRL, d, r);
    chk(d, 32'h0);
    $display("mid-run reset test done");
    conclude();
  end
endmodule

bind dec_event_counter dec_event_counter_props u_props (
  .clk_sys, .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
